//--- acvix_core.sv
// command frame execution for accumulator velocity and indexed variables
// What this block does
// - rotate-right opcode: velocity mode, accumulator to velocity
// - rotation direction increments position, microsteps per second
// - set-indexed writes value field at X
// - ignore indexed commands when X outside 0..255
// - get-indexed copies variable at X to accumulator
// - accumulator-to-indexed copies accumulator to variable at X
// - frame bytes: address, opcode, type, motor, value, checksum
`timescale 1ns/100ps
`include "acvix_regs.svh"
module acvix_core #(
    parameter int VAR_COUNT = 256
) (
    input  wire logic                   CLOCK,
    input  wire logic                   RST_N,
    input  wire logic                   BYTE_VALID,
    input  wire logic [7:0]             BYTE_DATA,
    input  wire logic                   STANDALONE,
    input  wire logic                   PROG_VALID,
    input  wire logic [7:0]             PROG_OPCODE,
    input  wire logic [31:0]            PROG_VALUE,
    input  wire logic                   X_WRITE,
    input  wire logic [31:0]            X_VALUE,
    input  wire logic                   ACC_WRITE,
    input  wire logic [31:0]            ACC_VALUE,
    output logic                        REPLY_VALID,
    output logic [7:0]                  REPLY_STATUS,
    output logic [7:0]                  REPLY_OPCODE,
    output logic [31:0]                 ACCUMULATOR,
    output acvix_pkg::acvix_mode_t      AXIS_MODE,
    output logic [31:0]                 TARGET_VELOCITY,
    output logic                        DIRECTION_UP,
    output logic                        VELOCITY_LOAD
);
    import acvix_pkg::*;

    typedef struct packed {
        acvix_state_t         state;
        logic [3:0]           count;
        logic [7:0]           sum;
        logic [7:0]           opcode;
        logic [31:0]          value;
        logic                 sum_ok;
        logic [31:0]          acc;
        logic [31:0]          x;
        acvix_mode_t          mode;
        logic [31:0]          velocity;
        logic                 dir_up;
        logic                 vel_load;
        logic                 reply_valid;
        logic [7:0]           reply_status;
        logic [7:0]           reply_opcode;
        logic [VAR_COUNT-1:0][31:0] vars;
    } acvix_core_t;

    acvix_core_t state_ff;
    acvix_core_t nxt_state;

    // index check: X is signed, so the whole word must lie in 0..255
    function automatic logic index_ok(input logic [31:0] x);
        index_ok = (x <= `ACVIX_INDEX_MAX);
    endfunction

    // byte pipe from the serial link; frames share the clock domain
    always_comb begin
        logic [7:0] idx;
        nxt_state = state_ff;
        idx = state_ff.x[7:0];
        nxt_state.vel_load = 1'b0;
        nxt_state.reply_valid = 1'b0;
        if (X_WRITE) begin
            nxt_state.x = X_VALUE;
        end
        if (ACC_WRITE) begin
            nxt_state.acc = ACC_VALUE;
        end
        case (state_ff.state)
            ACVIX_COLLECT: begin
                if (STANDALONE) begin
                    nxt_state.count = 4'h0;
                    nxt_state.sum = 8'h00;
                    if (PROG_VALID) begin
                        nxt_state.opcode = PROG_OPCODE;
                        nxt_state.value = PROG_VALUE;
                        nxt_state.sum_ok = 1'b1;
                        nxt_state.state = ACVIX_EXECUTE;
                    end
                end else if (BYTE_VALID) begin
                    // byte order: address, opcode, type, motor, value msb first
                    case (state_ff.count)
                        4'h1: nxt_state.opcode = BYTE_DATA;
                        4'h4, 4'h5, 4'h6, 4'h7: begin
                            nxt_state.value = {state_ff.value[23:0],
                                               BYTE_DATA};
                        end
                        default: ;
                    endcase
                    nxt_state.sum = state_ff.sum + BYTE_DATA;
                    nxt_state.count = state_ff.count + 4'h1;
                    if (state_ff.count == `ACVIX_FRAME_BYTES - 4'h1) begin
                        nxt_state.sum_ok = (state_ff.sum == BYTE_DATA);
                        nxt_state.count = 4'h0;
                        nxt_state.sum = 8'h00;
                        nxt_state.state = ACVIX_EXECUTE;
                    end
                end
            end
            ACVIX_EXECUTE: begin
                nxt_state.reply_status = `ACVIX_STATUS_OK;
                if (!state_ff.sum_ok) begin
                    nxt_state.reply_status = `ACVIX_STATUS_BAD_SUM;
                end else if (state_ff.opcode == `ACVIX_OP_ROTATE_RIGHT_ACC) begin
                    nxt_state.mode = ACVIX_VELOCITY;
                    nxt_state.velocity = state_ff.acc;
                    nxt_state.dir_up = 1'b1;
                    nxt_state.vel_load = 1'b1;
                end else if (state_ff.opcode == `ACVIX_OP_SET_INDEXED) begin
                    if (index_ok(state_ff.x)) begin
                        nxt_state.vars[idx] = state_ff.value;
                    end
                end else if (state_ff.opcode == `ACVIX_OP_GET_INDEXED) begin
                    if (index_ok(state_ff.x)) begin
                        nxt_state.acc = state_ff.vars[idx];
                    end
                end else if (state_ff.opcode == `ACVIX_OP_ACC_TO_INDEXED) begin
                    if (index_ok(state_ff.x)) begin
                        nxt_state.vars[idx] = state_ff.acc;
                    end
                end else begin
                    nxt_state.reply_status = `ACVIX_STATUS_BAD_OP;
                end
                nxt_state.reply_opcode = state_ff.opcode;
                nxt_state.state = ACVIX_REPLY;
            end
            ACVIX_REPLY: begin
                // stored programs take no reply
                nxt_state.reply_valid = !STANDALONE;
                nxt_state.state = ACVIX_COLLECT;
            end
            default: nxt_state.state = ACVIX_COLLECT;
        endcase
        if (!RST_N) begin
            nxt_state = '0;
            nxt_state.state = ACVIX_COLLECT;
            nxt_state.mode = ACVIX_POSITION;
            nxt_state.acc = `ACVIX_ACC_RESET;
            nxt_state.x = `ACVIX_X_RESET;
        end
    end

    always_ff @(posedge CLOCK) begin
        state_ff <= nxt_state;
    end

    assign REPLY_VALID     = state_ff.reply_valid;
    assign REPLY_STATUS    = state_ff.reply_status;
    assign REPLY_OPCODE    = state_ff.reply_opcode;
    assign ACCUMULATOR     = state_ff.acc;
    assign AXIS_MODE       = state_ff.mode;
    assign TARGET_VELOCITY = state_ff.velocity;
    assign DIRECTION_UP    = state_ff.dir_up;
    assign VELOCITY_LOAD   = state_ff.vel_load;

    property p_rotate_loads;
        @(posedge CLOCK) disable iff (!RST_N)
        VELOCITY_LOAD |-> AXIS_MODE == ACVIX_VELOCITY
            && TARGET_VELOCITY == $past(state_ff.acc);
    endproperty
    a_rotate_loads: assert property (p_rotate_loads)
        else $error("velocity not loaded from accumulator");

    property p_rotate_dir;
        @(posedge CLOCK) disable iff (!RST_N)
        VELOCITY_LOAD |-> DIRECTION_UP;
    endproperty
    a_rotate_dir: assert property (p_rotate_dir)
        else $error("rotation not upward");

    property p_set_var;
        @(posedge CLOCK) disable iff (!RST_N)
        state_ff.state == ACVIX_EXECUTE && state_ff.sum_ok
        && state_ff.opcode == `ACVIX_OP_SET_INDEXED && index_ok(state_ff.x)
        |=> state_ff.vars[$past(state_ff.x[7:0])] == $past(state_ff.value);
    endproperty
    a_set_var: assert property (p_set_var)
        else $error("set indexed variable failed");

    property p_ignore_range;
        @(posedge CLOCK) disable iff (!RST_N)
        state_ff.state == ACVIX_EXECUTE && !index_ok(state_ff.x)
        && !X_WRITE && !ACC_WRITE
        && state_ff.opcode != `ACVIX_OP_ROTATE_RIGHT_ACC
        |=> $stable(state_ff.vars) && $stable(state_ff.acc);
    endproperty
    a_ignore_range: assert property (p_ignore_range)
        else $error("out of range index not ignored");

    property p_get_var;
        @(posedge CLOCK) disable iff (!RST_N)
        state_ff.state == ACVIX_EXECUTE && state_ff.sum_ok && !ACC_WRITE
        && state_ff.opcode == `ACVIX_OP_GET_INDEXED && index_ok(state_ff.x)
        |=> ACCUMULATOR == $past(state_ff.vars[state_ff.x[7:0]]);
    endproperty
    a_get_var: assert property (p_get_var)
        else $error("get indexed variable failed");

    property p_acc_var;
        @(posedge CLOCK) disable iff (!RST_N)
        state_ff.state == ACVIX_EXECUTE && state_ff.sum_ok
        && state_ff.opcode == `ACVIX_OP_ACC_TO_INDEXED && index_ok(state_ff.x)
        |=> state_ff.vars[$past(state_ff.x[7:0])] == $past(state_ff.acc);
    endproperty
    a_acc_var: assert property (p_acc_var)
        else $error("accumulator to indexed variable failed");

    property p_reply_ok;
        @(posedge CLOCK) disable iff (!RST_N)
        state_ff.state == ACVIX_EXECUTE && state_ff.sum_ok
        && state_ff.opcode == `ACVIX_OP_GET_INDEXED && !STANDALONE
        ##1 !STANDALONE
        |=> REPLY_VALID && REPLY_STATUS == `ACVIX_STATUS_OK;
    endproperty
    a_reply_ok: assert property (p_reply_ok)
        else $error("missing OK reply");

    property p_bad_sum;
        @(posedge CLOCK) disable iff (!RST_N)
        state_ff.state == ACVIX_EXECUTE && !state_ff.sum_ok
        |=> REPLY_STATUS == `ACVIX_STATUS_BAD_SUM && $stable(state_ff.vars);
    endproperty
    a_bad_sum: assert property (p_bad_sum)
        else $error("bad checksum frame executed");

    c_rotate: cover property (@(posedge CLOCK) VELOCITY_LOAD);
    c_reply: cover property (@(posedge CLOCK) REPLY_VALID);
    c_bad: cover property (@(posedge CLOCK)
        REPLY_VALID && REPLY_STATUS == `ACVIX_STATUS_BAD_SUM);
endmodule

//--- acvix_regs.svh
// constants for the accumulator velocity and indexed variable block
`ifndef ACVIX_REGS_SVH
`define ACVIX_REGS_SVH
`define ACVIX_OP_ROTATE_RIGHT_ACC 8'h33
`define ACVIX_OP_SET_INDEXED      8'h37
`define ACVIX_OP_GET_INDEXED      8'h38
`define ACVIX_OP_ACC_TO_INDEXED   8'h39
`define ACVIX_STATUS_OK           8'h64
`define ACVIX_STATUS_BAD_SUM      8'h01
`define ACVIX_STATUS_BAD_OP       8'h02
`define ACVIX_FRAME_BYTES         4'h9
`define ACVIX_ACC_RESET           32'h0000_0000
`define ACVIX_X_RESET             32'h0000_0000
`define ACVIX_INDEX_MAX           32'h0000_00FF
`endif

//--- acvix_pkg.sv
// types for the accumulator velocity and indexed variable block
package acvix_pkg;
    typedef enum logic [1:0] {
        ACVIX_POSITION,
        ACVIX_VELOCITY
    } acvix_mode_t;
    typedef enum logic [1:0] {
        ACVIX_COLLECT,
        ACVIX_EXECUTE,
        ACVIX_REPLY
    } acvix_state_t;
endpackage

//--- acvix_host_model.sv
// host model that frames commands into checksummed bytes
`timescale 1ns/100ps
module acvix_host_model (
    input  wire logic       clock,
    output logic            byte_valid,
    output logic [7:0]      byte_data
);
    initial begin
        byte_valid = 1'b0;
        byte_data  = 8'h00;
    end
    // idle data keeps changing so a stale byte never looks like a fresh one
    always @(posedge clock) begin
        if (!byte_valid)
            byte_data <= ~byte_data;
    end
    // slow mode leaves an idle cycle after every byte
    task automatic send_frame(input logic [7:0] op, input logic [31:0] val,
                              input logic bad, input int slow);
        logic [7:0] b [9];
        logic [7:0] sum;
        b = '{8'h01, op, 8'h00, 8'h00, val[31:24], val[23:16], val[15:8],
              val[7:0], 8'h00};
        sum = 8'h00;
        for (int i = 0; i < 8; i++)
            sum += b[i];
        b[8] = bad ? ~sum : sum;
        for (int i = 0; i < 9; i++) begin
            @(posedge clock);
            #1;
            byte_valid = 1'b1;
            byte_data  = b[i];
            if (slow != 0) begin
                @(posedge clock);
                #1;
                byte_valid = 1'b0;
            end
        end
        @(posedge clock);
        #1;
        byte_valid = 1'b0;
    endtask
endmodule

//--- acvix_core_tb.sv
// self-checking bench for the accumulator velocity and indexed variables
`timescale 1ns/100ps
`include "acvix_regs.svh"
module acvix_core_tb;
    import acvix_pkg::*;
    logic        clock, rst_n, standalone, prog_valid, x_write, acc_write;
    logic        byte_valid, reply_valid, direction_up, velocity_load;
    logic [7:0]  byte_data, prog_opcode, reply_status, reply_opcode, op;
    logic [31:0] prog_value, x_value, acc_value, accumulator, target_velocity;
    logic [31:0] seed, xv, exp_acc, exp_x, exp_vel, vars [256];
    acvix_mode_t axis_mode, exp_mode;
    logic        exp_dir;
    int          num_errors, samples_checked, replies, loads, exp_rep, exp_ld;
    logic [7:0]  ops [4] = '{`ACVIX_OP_ROTATE_RIGHT_ACC, `ACVIX_OP_SET_INDEXED,
                             `ACVIX_OP_GET_INDEXED, `ACVIX_OP_ACC_TO_INDEXED};
    logic [31:0] cx [4] = '{32'h0000_0000, 32'h0000_00FF, 32'h0000_0100,
                            32'hFFFF_FFFF};
    acvix_core i_acvix_core (.CLOCK(clock), .RST_N(rst_n),
        .BYTE_VALID(byte_valid), .BYTE_DATA(byte_data), .STANDALONE(standalone),
        .PROG_VALID(prog_valid), .PROG_OPCODE(prog_opcode),
        .PROG_VALUE(prog_value), .X_WRITE(x_write), .X_VALUE(x_value),
        .ACC_WRITE(acc_write), .ACC_VALUE(acc_value),
        .REPLY_VALID(reply_valid), .REPLY_STATUS(reply_status),
        .REPLY_OPCODE(reply_opcode), .ACCUMULATOR(accumulator),
        .AXIS_MODE(axis_mode), .TARGET_VELOCITY(target_velocity),
        .DIRECTION_UP(direction_up), .VELOCITY_LOAD(velocity_load));
    acvix_host_model i_acvix_host_model (.clock(clock),
        .byte_valid(byte_valid), .byte_data(byte_data));
    always #10 clock = ~clock;
    always @(posedge clock) begin
        replies += (reply_valid === 1'b1);
        loads += (velocity_load === 1'b1);
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic void predict(input logic [7:0] o, input logic [31:0] v);
        logic ok;
        ok = !exp_x[31] && exp_x <= `ACVIX_INDEX_MAX;
        if (o == `ACVIX_OP_ROTATE_RIGHT_ACC) begin
            exp_vel = exp_acc;
            exp_mode = ACVIX_VELOCITY;
            exp_dir = 1'b1;
            exp_ld++;
        end
        else if (ok && o == `ACVIX_OP_SET_INDEXED)
            vars[exp_x[7:0]] = v;
        else if (ok && o == `ACVIX_OP_GET_INDEXED)
            exp_acc = vars[exp_x[7:0]];
        else if (ok && o == `ACVIX_OP_ACC_TO_INDEXED)
            vars[exp_x[7:0]] = exp_acc;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic check_state;
        chk(accumulator, exp_acc);
        chk(target_velocity, exp_vel);
        chk(32'(axis_mode), 32'(exp_mode));
        chk(32'(direction_up), 32'(exp_dir));
        chk(loads, exp_ld);
    endtask
    task automatic load_xa(input logic [31:0] x, input logic [31:0] a);
        @(posedge clock);
        #1;
        {x_write, x_value, acc_write, acc_value} = {1'b1, x, 1'b1, a};
        @(posedge clock);
        #1;
        {x_write, acc_write} = 2'b00;
        {exp_x, exp_acc} = {x, a};
    endtask
    task automatic direct(input logic [7:0] o, input logic [31:0] v,
                          input logic bad, input int slow);
        int n;
        logic [7:0] es;
        // opcodes outside the four handled here come back as unknown
        es = (o inside {ops}) ? `ACVIX_STATUS_OK : `ACVIX_STATUS_BAD_OP;
        i_acvix_host_model.send_frame(o, v, bad, slow);
        n = 0;
        while (reply_valid !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        exp_rep++;
        chk(reply_valid, 1'b1);
        chk(reply_status, bad ? `ACVIX_STATUS_BAD_SUM : es);
        chk(reply_opcode, o);
        if (!bad)
            predict(o, v);
        @(posedge clock);
        #1;
        chk(reply_valid, 1'b0);
        check_state();
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        end_sim();
    end
    initial begin
        {clock, rst_n, standalone, prog_valid, x_write, acc_write} = '0;
        {prog_opcode, prog_value, x_value, acc_value} = '0;
        {exp_acc, exp_x, exp_vel, exp_dir, exp_rep, exp_ld} = '0;
        exp_mode = ACVIX_POSITION;
        seed = 32'hBCDB7878;
        foreach (vars[i])
            vars[i] = 32'h0000_0000;
        repeat (6) @(posedge clock);
        #1;
        rst_n = 1'b1;
        check_state();
        for (int k = 0; k < 48; k++) begin
            seed = lfsr(seed);
            xv = (k % 4 == 0) ? cx[(k / 4) % 4] : {29'h0, seed[2:0]};
            load_xa(xv, seed ^ 32'h5A5A_0F0F);
            seed = lfsr(seed);
            op = (k < 4) ? ops[k] : ops[seed[1:0]];
            direct(op, seed, k % 9 == 4, int'(seed[4]));
        end
        // rotate left lives outside this block, so it must be refused
        direct(8'h32, seed, 1'b0, 0);
        // stored-program commands run without any reply
        load_xa(32'h0000_0003, seed);
        for (int j = 0; j < 4; j++) begin
            @(posedge clock);
            #1;
            {standalone, prog_valid, prog_opcode} = {2'b11, ops[3 - j]};
            prog_value = lfsr(seed);
            @(posedge clock);
            #1;
            prog_valid = 1'b0;
            repeat (3) @(posedge clock);
            #1;
            standalone = 1'b0;
            predict(ops[3 - j], prog_value);
            check_state();
        end
        chk(replies, exp_rep);
        end_sim();
    end
endmodule
